// ### rtl/nsr_cfg.svh
// Offsets, field positions, reset values and codes of the status, interrupt, data and address
// registers of the program controller.
// Assumes a 32-bit APB slave, one aligned word per printed byte register.
// Behaviour
// - Status bits 6:4 keep the latest error; writing zero there clears it.
// - Error codes: 0 none, 1 unsupported command, 2 protected section write.
// - Code 3 when a new write/erase starts while one is running.
// - Status bit 1 reads one while EEPROM programming runs.
// - Status bit 0 reads one while flash programming runs.
// - Enable register bit 0 enables the EEPROM-ready interrupt.
// - Interrupt is a level: idle flag and enable both one.
// - Idle flag is set every cycle the EEPROM is not busy.
// - Writing one clears the idle flag while the EEPROM is busy; writing zero leaves it.
// - Read data is two bytes: low at base, high at base plus one.
// - Read data register loads the latest value read from memory or controller.
// - EEPROM reads use only the low byte of the read data register.
// - Address register is three bytes at base, base plus one, base plus two.
// - Address register records last location accessed, sized to the memory.
// - All logic runs on the CPU clock.
`ifndef NSR_CFG_SVH
`define NSR_CFG_SVH

`define NSR_IDX_STATUS   8'h02
`define NSR_IDX_IRQ_EN   8'h03
`define NSR_IDX_IRQ_FLAG 8'h04
`define NSR_IDX_DATA     8'h06
`define NSR_IDX_ADDR     8'h08

`define NSR_ERR_MSB      6
`define NSR_ERR_LSB      4
`define NSR_EE_BUSY_BIT  1
`define NSR_FL_BUSY_BIT  0
`define NSR_IDLE_BIT     0

`define NSR_ERR_NONE     3'h0
`define NSR_ERR_UNSUP    3'h1
`define NSR_ERR_PROT     3'h2
`define NSR_ERR_OVERLAP  3'h3

`define NSR_RST_BYTE     8'h00
`define NSR_CMD_IDLE     7'h00
`define NSR_CMD_NULL     7'h01

`endif

// ### rtl/nsr_pkg.sv
// Types shared by the register block of the program controller.
// Assumes the constants header is included by the files that need the figures.
package nsr_pkg;
    typedef logic [7:0]  nsr_byte_t;
    typedef logic [2:0]  nsr_err_t;
    typedef logic [6:0]  nsr_cmd_t;
    typedef enum logic [2:0]
    {
        NSR_SETUP  = 3'b001,
        NSR_ACCESS = 3'b010,
        NSR_DONE   = 3'b100
    } nsr_apb_e;
endpackage

// ### rtl/nsr_byte_reg.sv
// One register byte lane with a hardware load and a byte-wide software write.
// Assumes load and write come from logic on the same clock.
`include "nsr_cfg.svh"

module nsr_byte_reg
(
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             hw_load,
    input  wire nsr_pkg::nsr_byte_t hw_data,
    input  wire logic             sw_write,
    input  wire nsr_pkg::nsr_byte_t sw_data,
    output nsr_pkg::nsr_byte_t    q
);
    import nsr_pkg::*;

    // A hardware load wins over a software write in the same cycle.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            q <= `NSR_RST_BYTE;
        else if (hw_load)
            q <= hw_data;
        else if (sw_write)
            q <= sw_data;
    end
endmodule

// ### rtl/nsr_regs.sv
// Status, interrupt, data and address registers of the nonvolatile program controller.
// Assumes the rest of the controller drives command, busy, error and read-path signals on
// the CPU clock, and an APB master on the same clock.
`include "nsr_cfg.svh"

module nsr_regs
#(
    parameter int ADDR_W = 24
)
(
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              eeprom_program_active,
    input  wire logic              flash_program_active,
    input  wire logic              unsupported_command_error,
    input  wire logic              protected_section_error,
    input  wire logic              wr_cmd_start,
    input  wire logic              rd_valid,
    input  wire logic              rd_is_eeprom,
    input  wire logic [15:0]       rd_value,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output nsr_pkg::nsr_err_t      error_code,
    output logic                   eeprom_busy_q,
    output logic                   flash_busy_q,
    output logic                   eeprom_ready_irq
);
    import nsr_pkg::*;

    nsr_err_t  err;
    logic      ee_busy;
    logic      fl_busy;
    logic      irq_en;
    logic      idle_flag;
    nsr_byte_t data_b [2];
    nsr_byte_t addr_b [3];
    logic      prog_running;
    logic      wr_hit;
    logic [7:0] idx;
    nsr_byte_t wbyte;
    nsr_byte_t next_rd;
    logic [23:0] addr_wide;
    logic      ee_load;

    function automatic logic hit(input logic [7:0] i, input logic [7:0] target);
        hit = (i == target);
    endfunction

    function automatic logic next_irq(input logic f, input logic e);
        next_irq = f & e;
    endfunction

    assign idx      = paddr[9:2];
    assign wbyte    = pwdata[7:0];
    assign wr_hit   = psel && penable && pready && pwrite && pstrb[0];
    assign prog_running = ee_busy || fl_busy;
    assign addr_wide = 24'(rd_addr);
    assign ee_load  = rd_valid && rd_is_eeprom;

    // Busy bits mirror the controller's programming state.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            ee_busy <= 1'b0;
            fl_busy <= 1'b0;
        end
        else
        begin
            ee_busy <= eeprom_program_active;
            fl_busy <= flash_program_active;
        end
    end

    // Error code: a new hardware error wins over a software clear.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            err <= `NSR_ERR_NONE;
        else if (wr_cmd_start && prog_running)
            err <= `NSR_ERR_OVERLAP;
        else if (protected_section_error)
            err <= `NSR_ERR_PROT;
        else if (unsupported_command_error)
            err <= `NSR_ERR_UNSUP;
        else if (wr_hit && hit(idx, `NSR_IDX_STATUS)
                 && wbyte[`NSR_ERR_MSB:`NSR_ERR_LSB] == `NSR_ERR_NONE)
            err <= `NSR_ERR_NONE;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            irq_en <= 1'b0;
        else if (wr_hit && hit(idx, `NSR_IDX_IRQ_EN))
            irq_en <= wbyte[`NSR_IDLE_BIT];
    end

    // Idle flag is set while the EEPROM is not busy; the set wins over a clear.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            idle_flag <= 1'b0;
        else if (!eeprom_program_active)
            idle_flag <= 1'b1;
        else if (wr_hit && hit(idx, `NSR_IDX_IRQ_FLAG) && wbyte[`NSR_IDLE_BIT])
            idle_flag <= 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            eeprom_ready_irq <= 1'b0;
        else
            eeprom_ready_irq <= next_irq(idle_flag, irq_en);
    end

    // Data lanes: the EEPROM path only refreshes the low byte.
    nsr_byte_reg u_data_lo
    (
        .clock    (clock),
        .rst_n    (rst_n),
        .hw_load  (rd_valid),
        .hw_data  (rd_value[7:0]),
        .sw_write (wr_hit && hit(idx, `NSR_IDX_DATA)),
        .sw_data  (wbyte),
        .q        (data_b[0])
    );

    nsr_byte_reg u_data_hi
    (
        .clock    (clock),
        .rst_n    (rst_n),
        .hw_load  (rd_valid && !rd_is_eeprom),
        .hw_data  (rd_value[15:8]),
        .sw_write (wr_hit && hit(idx, `NSR_IDX_DATA + 8'h01)),
        .sw_data  (wbyte),
        .q        (data_b[1])
    );

    generate
        for (genvar g = 0; g < 3; g++)
        begin : g_addr
            nsr_byte_reg u_addr
            (
                .clock    (clock),
                .rst_n    (rst_n),
                .hw_load  (rd_valid),
                .hw_data  (addr_wide[8*g +: 8]),
                .sw_write (wr_hit && hit(idx, `NSR_IDX_ADDR + 8'(g))),
                .sw_data  (wbyte),
                .q        (addr_b[g])
            );
        end
    endgenerate

    // Read mux; unmapped words read zero.
    always_comb
    begin
        next_rd = 8'h00;
        unique case (idx)
            `NSR_IDX_STATUS:
                next_rd = {1'b0, err, 2'b00, ee_busy, fl_busy};
            `NSR_IDX_IRQ_EN:   next_rd = {7'h00, irq_en};
            `NSR_IDX_IRQ_FLAG: next_rd = {7'h00, idle_flag};
            `NSR_IDX_DATA:            next_rd = data_b[0];
            `NSR_IDX_DATA + 8'h01:    next_rd = data_b[1];
            `NSR_IDX_ADDR:            next_rd = addr_b[0];
            `NSR_IDX_ADDR + 8'h01:    next_rd = addr_b[1];
            `NSR_IDX_ADDR + 8'h02:    next_rd = addr_b[2];
            default:                  next_rd = 8'h00;
        endcase
    end

    // APB: one wait state; pready rises in the second access cycle.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && penable && !pready;
            pslverr <= 1'b0;
            if (psel && penable && !pready && !pwrite)
                prdata <= {24'h00_0000, next_rd};
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            error_code    <= `NSR_ERR_NONE;
            eeprom_busy_q <= 1'b0;
            flash_busy_q  <= 1'b0;
        end
        else
        begin
            error_code    <= err;
            eeprom_busy_q <= ee_busy;
            flash_busy_q  <= fl_busy;
        end
    end

    property p_busy_mirror;
        @(posedge clock) disable iff (!rst_n)
        rst_n |=> (ee_busy == $past(eeprom_program_active))
              && (fl_busy == $past(flash_program_active));
    endproperty
    a_busy_mirror: assert property (p_busy_mirror) else $error("busy bits stale");

    property p_overlap;
        @(posedge clock) disable iff (!rst_n)
        (wr_cmd_start && prog_running) |=> (err == `NSR_ERR_OVERLAP);
    endproperty
    a_overlap: assert property (p_overlap) else $error("overlap code missing");

    property p_prot;
        @(posedge clock) disable iff (!rst_n)
        (protected_section_error && !(wr_cmd_start && prog_running)) |=> err == `NSR_ERR_PROT;
    endproperty
    a_prot: assert property (p_prot) else $error("protect code missing");

    sequence s_err_clear;
        wr_hit && hit(idx, `NSR_IDX_STATUS) && wbyte[6:4] == 3'h0
        && !protected_section_error && !unsupported_command_error
        && !(wr_cmd_start && prog_running);
    endsequence
    property p_err_clear;
        @(posedge clock) disable iff (!rst_n)
        s_err_clear |=> err == `NSR_ERR_NONE;
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("error not cleared");

    property p_idle_set;
        @(posedge clock) disable iff (!rst_n)
        rst_n && !eeprom_program_active |=> idle_flag;
    endproperty
    a_idle_set: assert property (p_idle_set) else $error("idle flag not set");

    property p_idle_clr;
        @(posedge clock) disable iff (!rst_n)
        (eeprom_program_active && wr_hit && hit(idx, `NSR_IDX_IRQ_FLAG) && wbyte[0])
        |=> !idle_flag;
    endproperty
    a_idle_clr: assert property (p_idle_clr) else $error("idle flag not cleared");

    property p_irq;
        @(posedge clock) disable iff (!rst_n)
        rst_n |=> eeprom_ready_irq == ($past(idle_flag) && $past(irq_en));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt level wrong");

    property p_en_write;
        @(posedge clock) disable iff (!rst_n)
        (wr_hit && hit(idx, `NSR_IDX_IRQ_EN)) |=> irq_en == $past(wbyte[0]);
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable not written");

    property p_ee_hi_keep;
        @(posedge clock) disable iff (!rst_n)
        (ee_load && !(wr_hit && hit(idx, `NSR_IDX_DATA + 8'h01))) |=> $stable(data_b[1]);
    endproperty
    a_ee_hi_keep: assert property (p_ee_hi_keep) else $error("high byte changed");

    property p_data_load;
        @(posedge clock) disable iff (!rst_n)
        rd_valid |=> data_b[0] == $past(rd_value[7:0]);
    endproperty
    a_data_load: assert property (p_data_load) else $error("data not loaded");

    property p_addr_load;
        @(posedge clock) disable iff (!rst_n)
        rd_valid |=> {addr_b[2], addr_b[1], addr_b[0]} == $past(addr_wide);
    endproperty
    a_addr_load: assert property (p_addr_load) else $error("address not loaded");

    sequence s_access_first;
        psel && penable && !pready;
    endsequence

    property p_apb_wait;
        @(posedge clock) disable iff (!rst_n)
        s_access_first |=> pready;
    endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("pready late");

    property p_ready_pulse;
        @(posedge clock) disable iff (!rst_n)
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held too long");

    property p_no_slverr;
        @(posedge clock) disable iff (!rst_n)
        rst_n |=> !pslverr;
    endproperty
    a_no_slverr: assert property (p_no_slverr) else $error("unexpected slave error");

    property p_rd_upper;
        @(posedge clock) disable iff (!rst_n)
        (s_access_first and !pwrite) |=> prdata[31:8] == 24'h00_0000;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");

    property p_unsup;
        @(posedge clock) disable iff (!rst_n)
        (unsupported_command_error && !protected_section_error
         && !(wr_cmd_start && prog_running)) |=> err == `NSR_ERR_UNSUP;
    endproperty
    a_unsup: assert property (p_unsup) else $error("unsupported code missing");

    property p_err_keep;
        @(posedge clock) disable iff (!rst_n)
        !(unsupported_command_error || protected_section_error
          || (wr_cmd_start && prog_running)
          || (wr_hit && hit(idx, `NSR_IDX_STATUS))) |=> $stable(err);
    endproperty
    a_err_keep: assert property (p_err_keep) else $error("error code lost");

    property p_flag_keep;
        @(posedge clock) disable iff (!rst_n)
        (rst_n && eeprom_program_active
         && !(wr_hit && hit(idx, `NSR_IDX_IRQ_FLAG) && wbyte[`NSR_IDLE_BIT])) |=> $stable(idle_flag);
    endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("idle flag changed");

    property p_data_hi_load;
        @(posedge clock) disable iff (!rst_n)
        (rd_valid && !rd_is_eeprom) |=> data_b[1] == $past(rd_value[15:8]);
    endproperty
    a_data_hi_load: assert property (p_data_hi_load) else $error("high byte not loaded");

    property p_byte_write;
        @(posedge clock) disable iff (!rst_n)
        (wr_hit && hit(idx, `NSR_IDX_DATA) && !rd_valid) |=> data_b[0] == $past(wbyte);
    endproperty
    a_byte_write: assert property (p_byte_write) else $error("data byte not written");

    property p_out_copy;
        @(posedge clock) disable iff (!rst_n)
        rst_n |=> error_code == $past(err);
    endproperty
    a_out_copy: assert property (p_out_copy) else $error("error output stale");
endmodule

// ### tb/nsr_cpu_model.sv
// APB master model that stands in for the CPU core on the register bus.
// Assumes one clock; each transfer begins at the next rising edge.
module nsr_cpu_model
(
    input  wire logic        clock,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pstrb = 4'hF;
    end

    // The request stays unchanged until pready is seen high at an edge, or for at most 16 access edges.
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd, output logic ok);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge clock);
        penable <= 1'b1;
        ok = 1'b0;
        rd = 8'h00;
        for (int n = 0; n < 16 && !ok; n++)
        begin
            @(posedge clock);
            ok = (pready === 1'b1);
            rd = prdata[7:0];
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// ### tb/nsr_regs_tb.sv
// Self-checking bench for the register block of the program controller.
// Assumes one 100 MHz clock drives the block, the CPU model and the bench.
`include "nsr_cfg.svh"

module nsr_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic              clock = 1'b0;
    logic              rst_n = 1'b0;
    logic              psel, penable, pwrite, pready, irq;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata;
    logic [3:0]        pstrb;
    logic [3:0]        pv = 4'h0;
    logic              ee_b = 1'b0, fl_b = 1'b0, rd_is_ee = 1'b0, ok, e;
    logic [15:0]       rd_value = 16'h0000, v;
    logic [23:0]       rd_addr = 24'h000000, a;
    logic [7:0]        got, exp_hi;
    logic [7:0]        w [5];
    logic [1:0]        b;
    logic [2:0]        err_o;
    logic              eb_q, fb_q, slverr;
    int                fail_count = 0;
    int                n_compared = 0;

    always #5 clock = ~clock;

    nsr_cpu_model cpu_u (.clock, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
                         .prdata, .pready);
    // Pulse lanes: 0 unsupported, 1 protected, 2 command start, 3 read result.
    nsr_regs #(.ADDR_W(24)) dut_u (.clock, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr(slverr), .eeprom_program_active(ee_b),
        .flash_program_active(fl_b), .unsupported_command_error(pv[0]),
        .protected_section_error(pv[1]), .wr_cmd_start(pv[2]), .rd_valid(pv[3]),
        .rd_is_eeprom(rd_is_ee), .rd_value, .rd_addr, .error_code(err_o),
        .eeprom_busy_q(eb_q), .flash_busy_q(fb_q), .eeprom_ready_irq(irq));

    function automatic logic [7:0] st_exp(input logic [2:0] er, input logic eb, input logic fb);
        return {1'b0, er, 2'b00, eb, fb};
    endfunction

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        n_compared++;
        if (g !== x)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    task automatic op(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        cpu_u.xfer(wr, idx, wd, got, ok);
        if (!ok)
        begin
            fail_count++;
            end_of_test();
        end
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] x);
        op(1'b0, idx, 8'h00);
        chk(got, x);
        chk({6'h00, slverr, |prdata[31:8]}, 8'h00);
    endtask

    task automatic rd_st(input logic [2:0] er, input logic eb, input logic fb);
        rd(`NSR_IDX_STATUS, st_exp(er, eb, fb));
        chk({5'h00, err_o}, {5'h00, er});
        chk({6'h00, eb_q, fb_q}, {6'h00, eb, fb});
    endtask

    task automatic pulse(input logic [3:0] p);
        @(posedge clock);
        pv <= p;
        @(posedge clock);
        pv <= 4'h0;
    endtask

    task automatic setb(input logic eb, input logic fb);
        @(posedge clock);
        ee_b <= eb;
        fl_b <= fb;
    endtask

    initial
    begin
        void'($urandom(24838));
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        rd(`NSR_IDX_STATUS, 8'h00);
        rd(`NSR_IDX_IRQ_EN, 8'h00);
        rd(`NSR_IDX_IRQ_FLAG, 8'h01);
        for (int k = 0; k < 5; k++)
            rd(`NSR_IDX_DATA + 8'(k), 8'h00);
        op(1'b1, 8'h05, 8'hA5);
        rd(8'h05, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            b = (i < 4) ? 2'(i) : 2'($urandom);
            setb(b[1], b[0]);
            rd_st(3'h0, b[1], b[0]);
        end
        setb(1'b0, 1'b0);
        $display("test busy done");
        pulse(4'h4);
        rd_st(`NSR_ERR_NONE, 1'b0, 1'b0);
        pulse(4'h1);
        rd_st(`NSR_ERR_UNSUP, 1'b0, 1'b0);
        op(1'b1, `NSR_IDX_STATUS, 8'h00);
        rd(`NSR_IDX_STATUS, 8'h00);
        pulse(4'h3);
        rd_st(`NSR_ERR_PROT, 1'b0, 1'b0);
        setb(1'b1, 1'b0);
        pulse(4'h4);
        rd_st(`NSR_ERR_OVERLAP, 1'b1, 1'b0);
        op(1'b1, `NSR_IDX_STATUS, 8'h00);
        setb(1'b0, 1'b1);
        pulse(4'h4);
        rd_st(`NSR_ERR_OVERLAP, 1'b0, 1'b1);
        op(1'b1, `NSR_IDX_STATUS, 8'h00);
        rd_st(`NSR_ERR_NONE, 1'b0, 1'b1);
        setb(1'b1, 1'b0);
        $display("test errors done");
        op(1'b1, `NSR_IDX_IRQ_FLAG, 8'h00);
        rd(`NSR_IDX_IRQ_FLAG, 8'h01);
        op(1'b1, `NSR_IDX_IRQ_FLAG, 8'h01);
        rd(`NSR_IDX_IRQ_FLAG, 8'h00);
        op(1'b1, `NSR_IDX_IRQ_EN, 8'h01);
        rd(`NSR_IDX_IRQ_EN, 8'h01);
        chk({7'h00, irq}, 8'h00);
        setb(1'b0, 1'b0);
        rd(`NSR_IDX_IRQ_FLAG, 8'h01);
        chk({7'h00, irq}, 8'h01);
        op(1'b1, `NSR_IDX_IRQ_EN, 8'h00);
        rd(`NSR_IDX_STATUS, 8'h00);
        chk({7'h00, irq}, 8'h00);
        op(1'b1, `NSR_IDX_IRQ_FLAG, 8'h01);
        rd(`NSR_IDX_IRQ_FLAG, 8'h01);
        $display("test interrupt done");
        exp_hi = 8'h00;
        for (int i = 0; i < 6; i++)
        begin
            v = 16'($urandom);
            a = 24'($urandom);
            e = (i == 0) ? 1'b1 : 1'($urandom);
            rd_value <= v;
            rd_addr <= a;
            rd_is_ee <= e;
            pulse(4'h8);
            if (!e)
                exp_hi = v[15:8];
            rd(`NSR_IDX_DATA, v[7:0]);
            rd(`NSR_IDX_DATA + 8'h01, exp_hi);
            for (int k = 0; k < 3; k++)
                rd(`NSR_IDX_ADDR + 8'(k), a[8*k +: 8]);
        end
        for (int k = 0; k < 5; k++)
        begin
            w[k] = 8'($urandom);
            op(1'b1, `NSR_IDX_DATA + 8'(k), w[k]);
        end
        for (int k = 0; k < 5; k++)
            rd(`NSR_IDX_DATA + 8'(k), w[k]);
        $display("test data and address done");
        end_of_test();
    end
endmodule
